// *** logic/byte_alu_core.sv ***
// byte_alu_core: accumulator, status, file registers and watchdog count
// behind an axi4-lite slave; a write to the instruction word executes it in the run state
// assumes wake_pin is asynchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module byte_alu_core (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [alu_subset_pkg::addr_w-1:0] awaddr,
  input  wire logic [2:0]                        awprot,
  input  wire logic                              wvalid,
  output logic                                   wready,
  input  wire logic [alu_subset_pkg::data_w-1:0] wdata,
  input  wire logic [3:0]                        wstrb,
  output logic                                   bvalid,
  input  wire logic                              bready,
  output logic [1:0]                             bresp,
  input  wire logic                              arvalid,
  output logic                                   arready,
  input  wire logic [alu_subset_pkg::addr_w-1:0] araddr,
  input  wire logic [2:0]                        arprot,
  output logic                                   rvalid,
  input  wire logic                              rready,
  output logic [alu_subset_pkg::data_w-1:0]      rdata,
  output logic [1:0]                             rresp,
  input  wire logic                              wake_pin,
  output logic                                   standby_active,
  output logic                                   osc_enable
);
  import alu_subset_pkg::*;

  function automatic logic is_file(input logic [addr_w-1:0] a);
    return a[addr_w-1:fadr_w+2] == file_base[addr_w-1:fadr_w+2];
  endfunction : is_file

  function automatic logic mapped(input logic [addr_w-1:0] a);
    return (a[1:0] == lane_zero) && (is_file(a) || a == instr_addr || a == acc_addr
           || a == status_addr || a == wdt_addr);
  endfunction : mapped

  function automatic logic [data_w-1:0] merge(input logic [data_w-1:0] old,
                                               input logic [data_w-1:0] nw,
                                               input logic [3:0] strb);
    logic [data_w-1:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[8*i +: 8] = nw[8*i +: 8];
    end
    return m;
  endfunction : merge

  // bus state
  logic              aw_held, next_aw_held, w_held, next_w_held;
  logic [addr_w-1:0] aw_addr, next_aw_addr;
  logic [data_w-1:0] w_data, next_w_data, next_rdata;
  logic [3:0]        w_strb, next_w_strb;
  logic              next_bvalid, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic              do_write;
  // core state
  core_type          state, next_state;
  logic [7:0]        acc, next_acc, wdt_count, next_wdt_count, wdt_presc, next_wdt_presc;
  logic              c, next_c, dc, next_dc, z, next_z, pd, next_pd, to, next_to;
  logic [data_w-1:0] instr, next_instr, instr_word, status_word, merged;
  logic [7:0]        file_mem [file_depth];
  logic              file_we;
  logic [fadr_w-1:0] file_waddr;
  logic [7:0]        file_wdata;
  logic              wake_meta, wake_sync, exec_fire;
  // decoded instruction and alu
  op_type            op;
  logic [7:0]        lit, file_val, result;
  logic [fadr_w-1:0] fadr;
  logic              dest, has_result, force_acc;
  logic              c_out, dc_out, z_out, upd_c, upd_dc, upd_z;

  assign awready        = !aw_held;
  assign wready         = !w_held;
  assign arready        = !rvalid;
  assign do_write       = aw_held && w_held && !bvalid;
  assign standby_active = (state == standby_state);
  assign osc_enable     = (state == run_state);
  assign merged         = merge(word_zero, w_data, w_strb);
  assign instr_word     = merge(instr, w_data, w_strb);
  assign op             = op_type'(instr_word[op_lsb +: op_w]);
  assign lit            = instr_word[lit_lsb +: 8];
  assign fadr           = instr_word[fadr_lsb +: fadr_w];
  assign dest           = instr_word[dest_bit];
  assign file_val       = file_mem[fadr];
  assign exec_fire      = do_write && aw_addr == instr_addr && state == run_state;

  always_comb begin
    status_word           = word_zero;
    status_word[c_bit]    = c;
    status_word[dc_bit]   = dc;
    status_word[z_bit]    = z;
    status_word[pd_bit]   = pd;
    status_word[to_bit]   = to;
    status_word[stby_bit] = standby_active;
  end

  byte_alu u_alu (
    .op         (op),
    .acc        (acc),
    .lit        (lit),
    .file_val   (file_val),
    .carry_in   (c),
    .result     (result),
    .has_result (has_result),
    .force_acc  (force_acc),
    .c_out      (c_out),
    .dc_out     (dc_out),
    .z_out      (z_out),
    .upd_c      (upd_c),
    .upd_dc     (upd_dc),
    .upd_z      (upd_z)
  );

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? resp_okay : resp_slverr;
    end
    if (bvalid && bready) next_bvalid = 1'b0;
    if (rvalid && rready) next_rvalid = 1'b0;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(araddr) ? resp_okay : resp_slverr;
      next_rdata  = word_zero;
      if (mapped(araddr)) begin
        if (is_file(araddr)) next_rdata[7:0] = file_mem[araddr[fadr_w+1:2]];
        else if (araddr == instr_addr) next_rdata = instr;
        else if (araddr == acc_addr) next_rdata[7:0] = acc;
        else if (araddr == status_addr) next_rdata = status_word;
        else next_rdata = {16'h0000, wdt_presc, wdt_count};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= instr_addr;
      w_held  <= 1'b0;
      w_data  <= word_zero;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= resp_okay;
      rvalid  <= 1'b0;
      rdata   <= word_zero;
      rresp   <= resp_okay;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  always_comb begin
    next_state     = state;
    next_acc       = acc;
    next_c         = c;
    next_dc        = dc;
    next_z         = z;
    next_pd        = pd;
    next_to        = to;
    next_instr     = instr;
    next_wdt_presc = wdt_presc + byte_one;
    next_wdt_count = (wdt_presc == presc_max) ? wdt_count + byte_one : wdt_count;
    file_we        = 1'b0;
    file_waddr     = aw_addr[fadr_w+1:2];
    file_wdata     = merged[7:0];
    if (state == standby_state && wake_sync) next_state = run_state;
    if (do_write && mapped(aw_addr)) begin
      if (is_file(aw_addr)) file_we = w_strb[0];
      else if (aw_addr == acc_addr && w_strb[0]) next_acc = merged[7:0];
      else if (aw_addr == status_addr && w_strb[0]) begin
        next_c  = merged[c_bit];
        next_dc = merged[dc_bit];
        next_z  = merged[z_bit];
      end
    end
    if (exec_fire) begin
      next_instr = instr_word;
      if (op == op_standby) begin
        next_wdt_count = byte_zero;
        next_wdt_presc = byte_zero;
        next_pd        = 1'b0;
        next_to        = 1'b1;
        next_state     = standby_state;
      end
      if (has_result) begin
        if (force_acc || dest == dest_acc) next_acc = result;
        else begin
          file_we    = 1'b1;
          file_waddr = fadr;
          file_wdata = result;
        end
      end
      if (upd_c) next_c = c_out;
      if (upd_dc) next_dc = dc_out;
      if (upd_z) next_z = z_out;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= run_state;
      acc       <= byte_zero;
      c         <= flag_rst;
      dc        <= flag_rst;
      z         <= flag_rst;
      pd        <= power_rst;
      to        <= power_rst;
      instr     <= word_zero;
      wdt_count <= byte_zero;
      wdt_presc <= byte_zero;
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      state     <= next_state;
      acc       <= next_acc;
      c         <= next_c;
      dc        <= next_dc;
      z         <= next_z;
      pd        <= next_pd;
      to        <= next_to;
      instr     <= next_instr;
      wdt_count <= next_wdt_count;
      wdt_presc <= next_wdt_presc;
      wake_meta <= wake_pin;
      wake_sync <= wake_meta;
    end
  end

  always_ff @(posedge aclk) begin
    if (file_we) file_mem[file_waddr] <= file_wdata;
  end

  // checking helpers
  logic [7:0] chk_sub_lit, chk_sub_file, chk_file_old;
  logic       chk_nb_lit, chk_nb_file, chk_lit_op;
  assign chk_sub_lit  = lit - acc;
  assign chk_sub_file = file_val - acc;
  assign chk_nb_lit   = lit >= acc;
  assign chk_nb_file  = file_val >= acc;
  assign chk_file_old = file_mem[fadr];
  assign chk_lit_op   = exec_fire && (op == op_sub_lit);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wdt_clear;
    exec_fire && op == op_standby |=> wdt_count == byte_zero && wdt_presc == byte_zero;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

  property p_standby_flags;
    exec_fire && op == op_standby |=> !pd && to && $stable(c) && $stable(dc) && $stable(z);
  endproperty
  a_standby_flags: assert property (p_standby_flags) else $error("standby flags wrong");

  property p_halt;
    exec_fire && op == op_standby ##1 !wake_sync [*2] |-> standby_active && !osc_enable;
  endproperty
  a_halt: assert property (p_halt) else $error("core did not halt");

  property p_no_exec_standby;
    standby_active |-> !exec_fire;
  endproperty
  a_no_exec_standby: assert property (p_no_exec_standby) else $error("ran while halted");

  property p_sub_lit;
    chk_lit_op |=> acc == $past(chk_sub_lit) && z == (acc == byte_zero);
  endproperty
  a_sub_lit: assert property (p_sub_lit) else $error("literal subtract wrong");

  property p_rrf;
    exec_fire && op == op_rrf |=> c == $past(chk_file_old[0]) && $stable(z) && $stable(dc);
  endproperty
  a_rrf: assert property (p_rrf) else $error("rotate carry wrong");

  property p_sub_file;
    exec_fire && op == op_sub_file && dest == dest_acc |=> acc == $past(chk_sub_file);
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("file subtract wrong");

  property p_swap;
    exec_fire && op == op_swap && dest == dest_file
      |=> file_mem[$past(fadr)] == {$past(chk_file_old[3:0]), $past(chk_file_old[7:4])}
          && $stable(c) && $stable(z);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_xor_lit;
    exec_fire && op == op_xor_lit |=> $stable(c) && $stable(dc) && z == (acc == byte_zero);
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("xor literal flags wrong");

  property p_xor_file;
    exec_fire && op == op_xor_file && dest == dest_file |=> $stable(acc) && $stable(c);
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("xor file destination wrong");

  property p_borrow;
    (chk_lit_op |=> c == $past(chk_nb_lit))
    and (exec_fire && op == op_sub_file |=> c == $past(chk_nb_file));
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow sense wrong");

  c_standby_wake: cover property (exec_fire && op == op_standby ##[1:20] osc_enable);
  c_sub_borrow: cover property (chk_lit_op && !chk_nb_lit);
  c_rrf_file: cover property (exec_fire && op == op_rrf && dest == dest_file);
  c_slverr: cover property (bvalid && bresp == resp_slverr);
endmodule : byte_alu_core
`default_nettype wire

// *** logic/alu_subset_pkg.sv ***
// alu_subset_pkg: constants and types for the byte alu instruction subset
// assumes one 10 MHz core clock and an axi4-lite master reaching the registers
// Notes on behaviour
// - The standby instruction clears the watchdog counter and its prescaler to zero.
// - The standby instruction clears the powerdown flag, sets the timeout flag, and keeps carry, half carry and zero.
// - After the standby instruction the core halts and executes nothing until a wake event arrives.
// - Literal minus accumulator writes the 8-bit difference to the accumulator and updates carry, half carry and zero.
// - Rotate right through carry moves the old carry into bit 7 and old bit 0 into carry, touching only carry.
// - File minus accumulator sends the difference to the chosen destination and updates carry, half carry and zero.
// - Nibble exchange swaps the two halves of the file register, writes the destination and keeps all flags.
// - Accumulator xor literal stores the result in the accumulator and updates only the zero flag.
// - Accumulator xor file writes the result to the chosen destination and updates only the zero flag.
// - File addresses run 0 to 127, destination bit 0 selects the accumulator and 1 the file register.
`default_nettype none
package alu_subset_pkg;
  localparam int addr_w     = 12;
  localparam int data_w     = 32;
  localparam int file_depth = 128;
  localparam int fadr_w     = 7;
  // register byte addresses
  localparam logic [addr_w-1:0] instr_addr  = 12'h000;
  localparam logic [addr_w-1:0] acc_addr    = 12'h004;
  localparam logic [addr_w-1:0] status_addr = 12'h008;
  localparam logic [addr_w-1:0] wdt_addr    = 12'h00c;
  localparam logic [addr_w-1:0] file_base   = 12'h200;
  // instruction word fields
  localparam int op_lsb   = 0;
  localparam int op_w     = 3;
  localparam int lit_lsb  = 4;
  localparam int fadr_lsb = 12;
  localparam int dest_bit = 19;
  // status word fields
  localparam int c_bit    = 0;
  localparam int dc_bit   = 1;
  localparam int z_bit    = 2;
  localparam int pd_bit   = 3;
  localparam int to_bit   = 4;
  localparam int stby_bit = 5;
  // watchdog word field
  localparam int presc_lsb = 8;
  localparam logic [7:0]        byte_zero   = 8'h00;
  localparam logic [7:0]        byte_one    = 8'h01;
  localparam logic [7:0]        presc_max   = 8'hff;
  localparam logic [data_w-1:0] word_zero   = 32'h0000_0000;
  localparam logic [1:0]        lane_zero   = 2'h0;
  localparam logic              dest_acc    = 1'b0;
  localparam logic              dest_file   = 1'b1;
  localparam logic              flag_rst    = 1'b0;
  localparam logic              power_rst   = 1'b1;
  localparam logic [1:0]        resp_okay   = 2'h0;
  localparam logic [1:0]        resp_slverr = 2'h2;
  typedef enum logic [op_w-1:0] {
    op_nop, op_standby, op_sub_lit, op_rrf, op_sub_file, op_swap, op_xor_lit, op_xor_file
  } op_type;
  typedef enum logic {run_state, standby_state} core_type;
endpackage : alu_subset_pkg
`default_nettype wire

// *** logic/byte_alu.sv ***
// byte_alu: combinational result and flag logic of the instruction subset
// assumes operands are stable for the cycle in which the caller commits
`timescale 1ns/10ps
`default_nettype none
module byte_alu (
  input  wire alu_subset_pkg::op_type op,
  input  wire logic [7:0]             acc,
  input  wire logic [7:0]             lit,
  input  wire logic [7:0]             file_val,
  input  wire logic                   carry_in,
  output logic [7:0]                  result,
  output logic                        has_result,
  output logic                        force_acc,
  output logic                        c_out,
  output logic                        dc_out,
  output logic                        z_out,
  output logic                        upd_c,
  output logic                        upd_dc,
  output logic                        upd_z
);
  import alu_subset_pkg::*;

  // {no borrow, no nibble borrow, difference}
  function automatic logic [9:0] sub_f(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, a} - {1'b0, b};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    return {~d[8], ~h[4], d[7:0]};
  endfunction : sub_f

  logic [9:0] diff;

  always_comb begin
    diff       = sub_f((op == op_sub_lit) ? lit : file_val, acc);
    result     = byte_zero;
    has_result = 1'b1;
    force_acc  = 1'b0;
    c_out      = carry_in;
    dc_out     = diff[8];
    upd_c      = 1'b0;
    upd_dc     = 1'b0;
    upd_z      = 1'b0;
    unique case (op)
      op_nop, op_standby: has_result = 1'b0;
      op_sub_lit, op_sub_file: begin
        result    = diff[7:0];
        c_out     = diff[9];
        upd_c     = 1'b1;
        upd_dc    = 1'b1;
        upd_z     = 1'b1;
        force_acc = (op == op_sub_lit);
      end
      op_rrf: begin
        result = {carry_in, file_val[7:1]};
        c_out  = file_val[0];
        upd_c  = 1'b1;
      end
      op_swap: result = {file_val[3:0], file_val[7:4]};
      op_xor_lit: begin
        result    = acc ^ lit;
        upd_z     = 1'b1;
        force_acc = 1'b1;
      end
      op_xor_file: begin
        result = acc ^ file_val;
        upd_z  = 1'b1;
      end
    endcase
    z_out = (result == byte_zero);
  end
endmodule : byte_alu
`default_nettype wire

// *** testbench/tb_top.sv ***
// tb_top: self-checking bench for byte_alu_core driven over axi4-lite
// assumes the register map, instruction fields and op codes of alu_subset_pkg
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import alu_subset_pkg::*;
  logic              aclk     = 1'b0;
  logic              aresetn  = 1'b0;
  logic              awvalid  = 1'b0;
  logic              wvalid   = 1'b0;
  logic              bready   = 1'b0;
  logic              arvalid  = 1'b0;
  logic              rready   = 1'b0;
  logic              wake_pin = 1'b0;
  logic [addr_w-1:0] awaddr   = '0;
  logic [addr_w-1:0] araddr   = '0;
  logic [31:0]       wdata    = '0;
  logic              awready, wready, bvalid, arready, rvalid, standby_active, osc_enable;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  int                errors     = 0;
  int                n_compared = 0;

  always #50 aclk = ~aclk;

  byte_alu_core dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .wake_pin(wake_pin), .standby_active(standby_active), .osc_enable(osc_enable)
  );

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [addr_w-1:0] fa(input logic [6:0] n);
    return file_base + {3'h0, n, 2'h0};
  endfunction : fa

  function automatic logic [31:0] ins(input op_type op, input logic [7:0] k,
                                      input logic [6:0] f, input logic d);
    return {12'h000, d, f, k, 1'b0, op};
  endfunction : ins

  // address and data offered together, each released once taken
  task automatic wr(input logic [addr_w-1:0] a, input logic [31:0] d,
                    input logic [1:0] er = resp_okay);
    int n;
    logic aw_go, w_go, b_go;
    logic [1:0] r;
    n = 0;
    b_go = 1'b0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_go && n < 40) begin
      @(negedge aclk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    @(posedge aclk);
    chk({29'h0, b_go, r}, {29'h0, 1'b1, er});
  endtask : wr

  task automatic rd(input logic [addr_w-1:0] a, output logic [31:0] d,
                    input logic [1:0] er = resp_okay);
    int n;
    logic ar_go, got;
    logic [1:0] r;
    n = 0;
    got = 1'b0;
    r = 2'h3;
    d = '0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && n < 40) begin
      @(negedge aclk);
      ar_go = arvalid && arready;
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_go) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    @(posedge aclk);
    chk({29'h0, got, r}, {29'h0, 1'b1, er});
  endtask : rd

  task automatic rchk(input logic [addr_w-1:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask : rchk

  task automatic t_reset();
    logic [31:0] d;
    rchk(status_addr, 32'h18, 32'h3f);
    rchk(acc_addr, 32'h0, 32'hff);
    chk({30'h0, standby_active, osc_enable}, 32'h1);
    rd(12'h010, d, resp_slverr);
    wr(12'h100, 32'h0, resp_slverr);
  endtask : t_reset

  task automatic sub_case(input logic fop, input logic [7:0] a, input logic [7:0] w,
                          input logic d, input logic [6:0] f);
    logic [7:0] r;
    logic [2:0] fl;
    r = a - w;
    fl = {r == 8'h00, a[3:0] >= w[3:0], a >= w};
    wr(acc_addr, {24'h0, w});
    wr(status_addr, 32'h0);
    if (fop) wr(fa(f), {24'h0, a});
    wr(instr_addr, ins(fop ? op_sub_file : op_sub_lit, a, f, d));
    rchk(acc_addr, {24'h0, (fop && d) ? w : r}, 32'hff);
    if (fop) rchk(fa(f), {24'h0, d ? r : a}, 32'hff);
    rchk(status_addr, {29'h0, fl}, 32'h7);
  endtask : sub_case

  task automatic t_rotate_swap();
    wr(status_addr, 32'h2);
    wr(fa(0), 32'h03);
    wr(instr_addr, ins(op_rrf, 8'h00, 7'd0, dest_acc));
    rchk(acc_addr, 32'h01, 32'hff);
    rchk(status_addr, 32'h3, 32'h7);
    rchk(fa(0), 32'h03, 32'hff);
    wr(fa(1), 32'h80);
    wr(instr_addr, ins(op_rrf, 8'h00, 7'd1, dest_file));
    rchk(fa(1), 32'hc0, 32'hff);
    rchk(status_addr, 32'h2, 32'h7);
    wr(status_addr, 32'h5);
    wr(fa(5), 32'h3c);
    wr(instr_addr, ins(op_swap, 8'h00, 7'd5, dest_file));
    rchk(fa(5), 32'hc3, 32'hff);
    wr(instr_addr, ins(op_swap, 8'h00, 7'd5, dest_acc));
    rchk(acc_addr, 32'h3c, 32'hff);
    rchk(status_addr, 32'h5, 32'h7);
  endtask : t_rotate_swap

  task automatic t_xor();
    wr(instr_addr, ins(op_xor_lit, 8'hc3, 7'd0, dest_file));
    rchk(acc_addr, 32'hff, 32'hff);
    rchk(status_addr, 32'h1, 32'h7);
    wr(instr_addr, ins(op_xor_lit, 8'hff, 7'd0, dest_acc));
    rchk(status_addr, 32'h5, 32'h7);
    wr(acc_addr, 32'h0f);
    wr(fa(64), 32'hf0);
    wr(instr_addr, ins(op_xor_file, 8'h00, 7'd64, dest_file));
    rchk(fa(64), 32'hff, 32'hff);
    rchk(acc_addr, 32'h0f, 32'hff);
    rchk(status_addr, 32'h1, 32'h7);
    wr(instr_addr, ins(op_xor_file, 8'h00, 7'd64, dest_acc));
    rchk(acc_addr, 32'hf0, 32'hff);
  endtask : t_xor

  task automatic t_standby();
    logic [31:0] d;
    int n;
    wr(status_addr, 32'h6);
    wr(instr_addr, ins(op_standby, 8'h00, 7'd0, dest_acc));
    chk({30'h0, standby_active, osc_enable}, 32'h2);
    rchk(status_addr, 32'h36, 32'h3f);
    rd(wdt_addr, d);
    chk({24'h0, d[7:0]}, 32'h0);
    chk({31'h0, d[15:8] < 8'h10}, 32'h1);
    wr(instr_addr, ins(op_xor_lit, 8'hff, 7'd0, dest_acc));
    rchk(acc_addr, 32'hf0, 32'hff);
    wake_pin <= 1'b1;
    n = 0;
    while (standby_active === 1'b1 && n < 10) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
    wake_pin <= 1'b0;
    chk({30'h0, standby_active, osc_enable}, 32'h1);
    rchk(status_addr, 32'h16, 32'h3f);
    wr(instr_addr, ins(op_xor_lit, 8'hff, 7'd0, dest_acc));
    rchk(acc_addr, 32'h0f, 32'hff);
  endtask : t_standby

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    sub_case(1'b0, 8'h03, 8'h05, dest_acc, 7'd0);
    sub_case(1'b0, 8'h03, 8'h03, dest_file, 7'd0);
    sub_case(1'b0, 8'hff, 8'h10, dest_acc, 7'd0);
    sub_case(1'b1, 8'h10, 8'h01, dest_file, 7'd127);
    sub_case(1'b1, 8'h00, 8'h01, dest_acc, 7'd0);
    t_rotate_swap();
    t_xor();
    t_standby();
    complete_run();
  end

  // whole run needs well under 2000 cycles
  initial begin
    #500000;
    errors++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
